// ===== tcs_regs.svh
// Register offsets, field positions, reset values and timing counts for the timer clock source
`ifndef TCS_REGS_SVH
`define TCS_REGS_SVH
`define TCS_CTRL_DATA_OFS   8'h43
`define TCS_IO_BIAS         8'h20
`define TCS_CTRL_IO_OFS     8'h23
`define TCS_CTRL_RESET      8'h00
`define TCS_BIT_HOLD        7
`define TCS_BIT_ASYNC_RST   1
`define TCS_BIT_SHARED_RST  0
`define TCS_CS_OFF          3'h0
`define TCS_CS_DIRECT       3'h1
`define TCS_CS_DIV8         3'h2
`define TCS_CS_DIV64        3'h3
`define TCS_CS_DIV256       3'h4
`define TCS_CS_DIV1024      3'h5
`define TCS_CS_EXT_FALL     3'h6
`define TCS_CS_EXT_RISE     3'h7
`define TCS_PRESCALE_W      10
`define TCS_ASYNC_RST_CYC   4'h3
`endif

// ===== tcs_pkg.sv
// Types shared by the timer clock source block
`default_nettype none
package tcs_pkg;
	// One register bus access
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic       io_space;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tcs_bus_t;
	// Progress of an async prescaler reset
	typedef enum logic [1:0] {TCS_IDLE, TCS_WAIT_ASYNC} tcs_async_state_t;
endpackage : tcs_pkg
`default_nettype wire

// ===== tcs_clock_source.sv
// Timer clock source: external pin sync, edge detect, prescaler and reset control
`timescale 1ns/1ns
`default_nettype none
`include "tcs_regs.svh"

// Notes on behaviour
// - Count pin synchronised each clock, then edge-detected
// - Select 7 rising edge, 6 falling edge
// - Pin edge to count enable within 2-3 cycles
// - Capture on rising clock edge only
// - External pulses bypass prescaler taps
// - Hold mode keeps written prescaler resets
// - Hold mode cleared clears both resets
// - Async reset bit clears itself normally
// - Async reset reads one until done
// - Shared reset bit clears itself normally
// - Register at data 0x43 and I/O 0x23
// - Async select picks crystal oscillator
// - No select means no timer pulses
// - Select 1 direct, 2-5 prescaler taps
// - Shared prescaler runs freely
module tcs_clock_source (
	input  wire logic             i_sys_clk,        // System clock 250 MHz
	input  wire logic             i_rst_n,          // Synchronous reset, low
	input  wire tcs_pkg::tcs_bus_t i_bus,           // Register access
	output logic [7:0]            o_rdata,          // Read data
	output logic                  o_hit,            // Access addressed this register
	input  wire logic [2:0]       i_clock_select_field, // Timer clock select
	input  wire logic             i_external_count_pin, // Asynchronous count pin
	input  wire logic             i_async_oscillator_select, // Async timer source
	input  wire logic             i_async_tick,     // Crystal domain tick, synchronised
	output logic                  o_timer_count_pulse, // Count enable, one cycle
	output logic                  o_async_count_pulse, // Async timer count enable
	output logic                  o_shared_prescaler_reset, // Shared prescaler held
	output logic                  o_async_prescaler_reset   // Async prescaler held
);
	//--------------------------------------------------------------
	// Register decode
	//--------------------------------------------------------------
	logic       wr_hit;
	logic       hold_mode;
	logic       async_rst;
	logic       shared_rst;
	logic [3:0] async_cnt;
	logic [9:0] prescale;
	logic       pin_meta;
	logic       pin_sync;
	logic       pin_prev;
	logic       edge_rise;
	logic       edge_fall;
	logic       tap;
	logic       next_pulse;

	// Address match in either space
	// dual address decode
	function automatic logic addr_match(input tcs_pkg::tcs_bus_t b);
		addr_match = b.io_space ? (b.addr == `TCS_CTRL_IO_OFS)
			: (b.addr == `TCS_CTRL_DATA_OFS);
	endfunction : addr_match

	assign o_hit  = (i_bus.wr | i_bus.rd) & addr_match(i_bus);
	assign wr_hit = i_bus.wr & addr_match(i_bus);

	// Read back control and live reset state, registered so data comes from flops
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_rdata <= `TCS_CTRL_RESET;
		end else begin
			o_rdata                      <= 8'h00;
			o_rdata[`TCS_BIT_HOLD]       <= hold_mode;
			o_rdata[`TCS_BIT_ASYNC_RST]  <= async_rst;
			o_rdata[`TCS_BIT_SHARED_RST] <= shared_rst;
		end
	end

	//--------------------------------------------------------------
	// Control bits
	//--------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			hold_mode <= 1'b0;
		end else if (wr_hit) begin
			hold_mode <= i_bus.wdata[`TCS_BIT_HOLD];
		end
	end

	// shared reset self clears unless held
	// held bits kept in hold mode
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			shared_rst <= 1'b0;
		end else if (wr_hit) begin
			shared_rst <= i_bus.wdata[`TCS_BIT_HOLD] & i_bus.wdata[`TCS_BIT_SHARED_RST];
		end else if (!hold_mode) begin
			shared_rst <= 1'b0;
		end
	end

	// async reset self clears unless held
	// stays set while async reset runs
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			async_rst <= 1'b0;
			async_cnt <= 4'h0;
		end else if (wr_hit) begin
			async_rst <= i_bus.wdata[`TCS_BIT_ASYNC_RST]
				& (i_bus.wdata[`TCS_BIT_HOLD] | i_async_oscillator_select);
			async_cnt <= (i_bus.wdata[`TCS_BIT_ASYNC_RST] & i_async_oscillator_select)
				? `TCS_ASYNC_RST_CYC : 4'h0;
		end else if (async_cnt != 4'h0) begin
			if (i_async_tick) begin
				async_cnt <= async_cnt - 4'h1;
			end
		end else if (!hold_mode) begin
			async_rst <= 1'b0;
		end
	end

	assign o_shared_prescaler_reset = shared_rst | (wr_hit & i_bus.wdata[`TCS_BIT_SHARED_RST]);
	assign o_async_prescaler_reset  = async_rst | (wr_hit & i_bus.wdata[`TCS_BIT_ASYNC_RST]);

	//--------------------------------------------------------------
	// Free-running shared prescaler
	//--------------------------------------------------------------
	// free running, only reset clears it
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n || o_shared_prescaler_reset) begin
			prescale <= 10'h000;
		end else begin
			prescale <= prescale + 10'h001;
		end
	end

	//--------------------------------------------------------------
	// Pin synchroniser and edge detector
	//--------------------------------------------------------------
	// two-flop sync then edge detect
	// all stages on rising clock edge
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
			pin_prev <= 1'b0;
		end else begin
			pin_meta <= i_external_count_pin;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	assign edge_rise = pin_sync & ~pin_prev;
	assign edge_fall = ~pin_sync & pin_prev;

	// Prescaler tap selection, terminal count of each divisor
	// direct and divided taps
	always_comb begin
		case (i_clock_select_field)
			`TCS_CS_OFF:      tap = 1'b0;
			`TCS_CS_DIRECT:   tap = 1'b1;
			`TCS_CS_DIV8:     tap = (prescale[2:0] == 3'h7);
			`TCS_CS_DIV64:    tap = (prescale[5:0] == 6'h3f);
			`TCS_CS_DIV256:   tap = (prescale[7:0] == 8'hff);
			`TCS_CS_DIV1024:  tap = (prescale == 10'h3ff);
			`TCS_CS_EXT_FALL: tap = edge_fall;
			`TCS_CS_EXT_RISE: tap = edge_rise;
			default:          tap = 1'b0;
		endcase
		next_pulse = tap;
	end

	// pin edge to enable within three cycles
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_timer_count_pulse <= 1'b0;
		end else begin
			o_timer_count_pulse <= next_pulse & ~o_shared_prescaler_reset;
		end
	end

	// async timer from crystal or system clock
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_async_count_pulse <= 1'b0;
		end else begin
			o_async_count_pulse <= ~o_async_prescaler_reset
				& (i_async_oscillator_select ? i_async_tick : 1'b1);
		end
	end

	//--------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------
	a_rise_pulse: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_clock_select_field == `TCS_CS_EXT_RISE) && edge_rise && !o_shared_prescaler_reset
		|=> o_timer_count_pulse) else $error("rising edge missed");
	a_off_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		$past(i_clock_select_field) == `TCS_CS_OFF |-> !o_timer_count_pulse)
		else $error("pulse with source off");
	a_pulse_single: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		o_timer_count_pulse && i_clock_select_field[2:1] == 2'b11 |=> !o_timer_count_pulse)
		else $error("external pulse too long");
	a_shared_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		!hold_mode && !wr_hit |=> !shared_rst) else $error("shared reset stuck");
	a_hold_keep: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		hold_mode && !wr_hit && shared_rst |=> shared_rst) else $error("hold lost");
	a_release_sync: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		wr_hit && !i_bus.wdata[`TCS_BIT_HOLD] |=> !shared_rst ##1 !shared_rst)
		else $error("no release");
	a_prescale_run: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		!o_shared_prescaler_reset |=> prescale == $past(prescale) + 10'h001)
		else $error("prescaler stalled");
	a_async_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		async_cnt != 4'h0 |-> async_rst) else $error("async reset read early");
	c_rise: cover property (@(posedge i_sys_clk) edge_rise ##3 o_timer_count_pulse);
	c_hold: cover property (@(posedge i_sys_clk) hold_mode && shared_rst);
	c_async: cover property (@(posedge i_sys_clk) async_cnt == `TCS_ASYNC_RST_CYC);
endmodule : tcs_clock_source
`default_nettype wire

// ===== tcs_ext_src.sv
// External clock source model for the timer count pin
`timescale 1ns/1ns
`default_nettype none
module tcs_ext_src (
	input  wire logic       i_sys_clk, // System clock
	input  wire logic       i_en,      // Run the clock
	input  wire logic [3:0] i_half,    // Half period in cycles
	output logic            o_pin      // Count pin
);
	logic [3:0] cnt = 4'h0;
	initial o_pin = 1'b0;
	// toggle only while enabled, halves above one cycle
	always @(negedge i_sys_clk) begin
		if (!i_en) cnt <= 4'h0;
		else if (cnt == i_half - 4'h1) begin
			cnt <= 4'h0;
			o_pin <= ~o_pin;
		end else cnt <= cnt + 4'h1;
	end
endmodule : tcs_ext_src
`default_nettype wire

// ===== tcs_clock_source_test.sv
// Self-checking testbench for the timer clock source
`timescale 1ns/1ns
`default_nettype none
module tcs_clock_source_test;
	logic clk = 0, rst_n = 0, osc = 0, tick = 0, en = 0, pin, pin_d = 0;
	logic [2:0] sel = 3'h0;
	tcs_pkg::tcs_bus_t bus = '0;
	logic [7:0] rdata, d, q_rd[$];
	logic hit, tpulse, apulse, srst, arst;
	int fail_count = 0, num_checks = 0, cyc = 0, pcount = 0, np = 0, p0, q_pl[$];
	// Window length and expected pulse count per internal select value
	int win[6] = '{16, 16, 16, 128, 512, 2048};
	logic [7:0] exp_pc[6] = '{8'h00, 8'h10, 8'h02, 8'h02, 8'h02, 8'h02};
	always #2 clk = ~clk;
	tcs_ext_src ext (.i_sys_clk(clk), .i_en(en), .i_half(4'h3), .o_pin(pin));
	tcs_clock_source uut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_bus(bus), .o_rdata(rdata),
		.o_hit(hit), .i_clock_select_field(sel), .i_external_count_pin(pin),
		.i_async_oscillator_select(osc), .i_async_tick(tick), .o_timer_count_pulse(tpulse),
		.o_async_count_pulse(apulse), .o_shared_prescaler_reset(srst),
		.o_async_prescaler_reset(arst));
	task automatic chk(input logic [7:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic acc(input logic wr, io, input logic [7:0] a, dd, input logic h);
		@(negedge clk) bus = '{wr, !wr, io, a, dd};
		@(negedge clk) chk({7'h0, hit}, {7'h0, h});
		bus = '0;
	endtask : acc
	task automatic rd(input logic io, input logic [7:0] a, e);
		q_rd.push_back(e);
		acc(0, io, a, 8'h00, 1);
	endtask : rd
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : complete_run
	// Read results compared against the driver's notes
	always @(posedge clk) begin
		#1;
		if (bus.rd && hit && q_rd.size() > 0) chk(rdata, q_rd.pop_front());
	end
	// Pin edges noted, count pulses checked for latency
	always @(negedge clk) begin
		if (tpulse) pcount <= pcount + 1;
		if (tpulse && q_pl.size() > 0) chk(8'(cyc - q_pl.pop_front()), 8'h03);
		if (pin !== pin_d && sel == (pin ? 3'h7 : 3'h6)) begin
			q_pl.push_back(cyc - 1);
			np++;
		end
		pin_d <= pin;
		cyc++;
	end
	initial begin
		#40000;
		fail_count++;
		complete_run();
	end
	initial begin
		void'($urandom(39315));
		repeat (8) @(negedge clk);
		rst_n = 1;
		rd(0, 8'h43, 8'h00);
		rd(1, 8'h23, 8'h00);
		acc(0, 0, 8'h44, 8'h00, 0);
		acc(0, 1, 8'h43, 8'h00, 0);
		acc(1, 0, 8'h43, 8'h03, 1);
		rd(0, 8'h43, 8'h00);
		d = 8'h80 | 8'($urandom & 3);
		acc(1, 1, 8'h23, d, 1);
		rd(0, 8'h43, d);
		chk({6'h0, arst, srst}, {6'h0, d[1:0]});
		acc(1, 0, 8'h43, 8'h00, 1);
		rd(1, 8'h23, 8'h00);
		$display("register test done");
		osc = 1;
		acc(1, 0, 8'h43, 8'h02, 1);
		rd(0, 8'h43, 8'h02);
		repeat (3) begin
			@(negedge clk) tick = 1;
			@(negedge clk) tick = 0;
		end
		repeat (3) @(negedge clk);
		rd(0, 8'h43, 8'h00);
		@(negedge clk) tick = 1;
		@(negedge clk) tick = 0;
		chk({7'h0, apulse}, 8'h01);
		@(negedge clk) chk({7'h0, apulse}, 8'h00);
		osc = 0;
		@(negedge clk) chk({7'h0, apulse}, 8'h01);
		$display("async reset test done");
		for (int i = 0; i < 6; i++) begin
			@(negedge clk) sel = 3'(i);
			repeat (2) @(negedge clk);
			p0 = pcount;
			repeat (win[i]) @(negedge clk);
			chk(8'(pcount - p0), exp_pc[i]);
		end
		// shared reset restarts divide by 8
		@(negedge clk) sel = 3'h2;
		acc(1, 0, 8'h43, 8'h01, 1);
		repeat (7) @(negedge clk);
		chk({7'h0, tpulse}, 8'h00);
		@(negedge clk) chk({7'h0, tpulse}, 8'h01);
		$display("internal select test done");
		// select changed only while the pin is still
		for (int s = 7; s >= 6; s--) begin
			@(negedge clk) sel = 3'(s);
			p0 = pcount;
			np = 0;
			en = 1;
			repeat (40) @(negedge clk);
			en = 0;
			repeat (6) @(negedge clk);
			chk(8'(pcount - p0), 8'(np));
		end
		sel = 3'h0;
		$display("external pin test done");
		complete_run();
	end
endmodule : tcs_clock_source_test
`default_nettype wire
